// ==== bench/datapath_model.sv ====
// behavioural instruction datapath feeding results, steps and interrupts
`timescale 1ns/10ps
`default_nettype none
module datapath_model
	import core_regs_pkg::*;
(
	// clock
	input wire logic clk_i,
	// arithmetic result
	output logic alu_upd_o,
	output logic [31:0] alu_result_o,
	output op_size_e alu_size_o,
	output logic alu_carry_o,
	output logic alu_overflow_o,
	// sequencing
	output logic pc_advance_o,
	output logic [2:0] pc_step_o,
	// interrupts
	output logic irq_req_o,
	output logic irq_maskable_o,
	output logic [2:0] irq_prio_o,
	output logic irq_ack_o,
	output logic irq_hw_o,
	output logic [5:0] sw_int_num_o,
	output logic [2:0] ack_level_o
);
	// idle strobes low; qualifiers carry junk so nothing leans on stale values
	initial begin
		{alu_upd_o, pc_advance_o, irq_req_o, irq_ack_o, irq_maskable_o} = 5'h00;
		{alu_result_o, alu_carry_o, alu_overflow_o, pc_step_o} = 37'h15a5a5a5a5;
		{irq_prio_o, irq_hw_o, sw_int_num_o, ack_level_o} = 13'h0aaa;
		alu_size_o = SIZE_WORD;
	end

	// one result, held over exactly the edge that takes it
	task automatic alu(input logic [31:0] res, input op_size_e sz, input logic c, input logic v);
		@(posedge clk_i);
		alu_upd_o <= 1'b1;
		alu_result_o <= res;
		alu_size_o <= sz;
		alu_carry_o <= c;
		alu_overflow_o <= v;
		@(posedge clk_i);
		alu_upd_o <= 1'b0;
		alu_result_o <= ~res;
	endtask

	// one instruction advance
	task automatic step(input logic [2:0] n);
		@(posedge clk_i);
		pc_advance_o <= 1'b1;
		pc_step_o <= n;
		@(posedge clk_i);
		pc_advance_o <= 1'b0;
		pc_step_o <= ~n;
	endtask

	// request is a level, left standing until changed
	task automatic req(input logic r, input logic m, input logic [2:0] p);
		@(posedge clk_i);
		irq_req_o <= r;
		irq_maskable_o <= m;
		irq_prio_o <= p;
	endtask

	// one-cycle acknowledge
	task automatic ack(input logic hw, input logic [5:0] num, input logic [2:0] lvl);
		@(posedge clk_i);
		irq_ack_o <= 1'b1;
		irq_hw_o <= hw;
		sw_int_num_o <= num;
		ack_level_o <= lvl;
		@(posedge clk_i);
		irq_ack_o <= 1'b0;
		ack_level_o <= ~lvl;
	endtask
endmodule
`default_nettype wire

// ==== bench/reg_file_checker.sv ====
// concurrent checks on the ports of the core register file
`timescale 1ns/10ps
`default_nettype none
module reg_file_checker
	import core_regs_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [BUS_AW-1:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [BUS_DW-1:0] rdata_o,
	// datapath side
	input wire logic alu_upd_i,
	input wire logic [31:0] alu_result_i,
	input wire op_size_e alu_size_i,
	input wire logic alu_carry_i,
	input wire logic alu_overflow_i,
	input wire logic pc_advance_i,
	input wire logic [2:0] pc_step_i,
	input wire logic irq_req_i,
	input wire logic irq_maskable_i,
	input wire logic [2:0] irq_prio_i,
	input wire logic irq_ack_i,
	input wire logic irq_hw_i,
	input wire logic [5:0] sw_int_num_i,
	input wire logic [2:0] ack_level_i,
	input wire logic irq_accept_o,
	// state
	input wire logic [LONG_ADDR_W-1:0] program_counter_o,
	input wire logic [FLAG_W-1:0] flags_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// result sign-extended from its operand size, so zero and sign read off one value
	logic [31:0] res_ext;
	always_comb begin
		case (alu_size_i)
			SIZE_BYTE: res_ext = {{24{alu_result_i[7]}}, alu_result_i[7:0]};
			SIZE_LONG: res_ext = alu_result_i;
			default: res_ext = {{16{alu_result_i[15]}}, alu_result_i[15:0]};
		endcase
	end

	// an arithmetic update that no acknowledge overrides
	sequence s_alu;
		alu_upd_i && !irq_ack_i;
	endsequence
	// an acknowledge that moves onto the interrupt stack
	sequence s_to_isp;
		irq_ack_i && (irq_hw_i || sw_int_num_i <= SW_INT_ISP_MAX);
	endsequence

	AST_CARRY: assert property (s_alu |=> flags_o[FLG_C] == $past(alu_carry_i))
		else $error("carry flag did not follow the result");
	AST_ZERO: assert property (s_alu |=> flags_o[FLG_Z] == ($past(res_ext) == 32'h0))
		else $error("zero flag wrong");
	AST_SIGN: assert property (s_alu |=> flags_o[FLG_S] == $past(res_ext[31]))
		else $error("sign flag wrong");
	AST_OVERFLOW: assert property (s_alu |=> flags_o[FLG_O] == $past(alu_overflow_i))
		else $error("overflow flag wrong");
	AST_ACK_CLEARS_I: assert property (irq_ack_i |=> !flags_o[FLG_I])
		else $error("interrupt enable kept after acknowledge");
	AST_ACK_TO_ISP: assert property (s_to_isp |=> !flags_o[FLG_U])
		else $error("stack select kept after acknowledge");
	AST_HIGH_SW_KEEPS_U: assert property (irq_ack_i && !irq_hw_i && sw_int_num_i > SW_INT_ISP_MAX
		|=> $stable(flags_o[FLG_U]))
		else $error("stack select changed on high software interrupt");
	AST_HW_LEVEL: assert property (irq_ack_i && irq_hw_i
		|=> flags_o[FLG_IPL_HI:FLG_IPL_LO] == $past(ack_level_i))
		else $error("priority level not loaded on hardware acknowledge");
	AST_ACCEPT: assert property (irq_accept_o == (irq_req_i && irq_prio_i >
		flags_o[FLG_IPL_HI:FLG_IPL_LO] && (flags_o[FLG_I] || !irq_maskable_i)))
		else $error("interrupt acceptance wrong");
	AST_PC_STEP: assert property (pc_advance_i && !(wr_i && addr_i == IDX_PC)
		|=> program_counter_o == $past(program_counter_o) + $past(pc_step_i))
		else $error("program counter did not step");
	AST_PC_READ: assert property (rd_i && addr_i == IDX_PC
		|=> rdata_o == {12'h000, $past(program_counter_o)})
		else $error("program counter read back wrong");
endmodule
bind cpu_core_register_file reg_file_checker chk_u (.mclk_i, .rst_n_i, .addr_i, .wr_i,
	.rd_i, .rdata_o, .alu_upd_i, .alu_result_i, .alu_size_i, .alu_carry_i, .alu_overflow_i,
	.pc_advance_i, .pc_step_i, .irq_req_i, .irq_maskable_i, .irq_prio_i, .irq_ack_i,
	.irq_hw_i, .sw_int_num_i, .ack_level_i, .irq_accept_o, .program_counter_o, .flags_o);
`default_nettype wire

// ==== bench/tb_cpu_core_register_file.sv ====
// self-checking bench for the core register file
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_cpu_core_register_file
	import core_regs_pkg::*;
;
	logic mclk_i, rst_n_i, wr_i, rd_i;
	logic [BUS_AW-1:0] addr_i;
	logic [BUS_DW-1:0] wdata_i, rdata_o;
	logic alu_upd, alu_c, alu_v, pc_adv, irq_req, irq_msk, irq_ack, irq_hw, irq_acc;
	logic [31:0] alu_res;
	op_size_e alu_size;
	logic [2:0] pc_step, irq_prio, ack_lvl;
	logic [5:0] sw_num;
	logic [19:0] pc, vtb;
	logic [15:0] asp, fb, sb;
	logic [10:0] flags;
	int err_count;
	int checked;

	datapath_model dp_u (.clk_i(mclk_i), .alu_upd_o(alu_upd), .alu_result_o(alu_res),
		.alu_size_o(alu_size), .alu_carry_o(alu_c), .alu_overflow_o(alu_v),
		.pc_advance_o(pc_adv), .pc_step_o(pc_step), .irq_req_o(irq_req),
		.irq_maskable_o(irq_msk), .irq_prio_o(irq_prio), .irq_ack_o(irq_ack),
		.irq_hw_o(irq_hw), .sw_int_num_o(sw_num), .ack_level_o(ack_lvl));
	cpu_core_register_file dut_u (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .alu_upd_i(alu_upd), .alu_result_i(alu_res), .alu_size_i(alu_size),
		.alu_carry_i(alu_c), .alu_overflow_i(alu_v), .pc_advance_i(pc_adv),
		.pc_step_i(pc_step), .irq_req_i(irq_req), .irq_maskable_i(irq_msk),
		.irq_prio_i(irq_prio), .irq_ack_i(irq_ack), .irq_hw_i(irq_hw),
		.sw_int_num_i(sw_num), .ack_level_i(ack_lvl), .irq_accept_o(irq_acc),
		.program_counter_o(pc), .active_stack_pointer_o(asp), .frame_base_o(fb),
		.static_base_o(sb), .vector_table_base_o(vtb), .flags_o(flags));

	// 40 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// one-cycle write; returns at the taking edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		wdata_i <= ~d;
	endtask

	// one-cycle read; data stands from the following cycle on
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		`CHK(rdata_o, e)
	endtask

	task automatic give_verdict();
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// byte, word and paired views of the data and address registers
	task automatic t_views();
		`CHK(flags, 11'h000)
		rd_chk(IDX_DATA0, 32'h0);
		wr(IDX_DATA0, 32'h1234);
		wr(IDX_DATA2, 32'habcd);
		rd_chk(IDX_PAIR_EVEN, 32'habcd1234);
		wr(IDX_D0_HI, 32'h5a);
		wr(IDX_D0_LO, 32'hffffff34);
		rd_chk(IDX_DATA0, 32'h5a34);
		rd_chk(IDX_D0_LO, 32'h34);
		rd_chk(IDX_D0_HI, 32'h5a);
		wr(IDX_PAIR_ODD, 32'h87654321);
		rd_chk(IDX_D1_HI, 32'h43);
		wr(IDX_D1_LO, 32'h9c);
		rd_chk(IDX_PAIR_ODD, 32'h8765439c);
		rd_chk(IDX_DATA3, 32'h8765);
		wr(IDX_ADDR_PAIR, 32'h0badf00d);
		rd_chk(IDX_ADDR1, 32'h0bad);
		rd_chk(IDX_ADDR0, 32'hf00d);
		// unmapped index swallows writes and reads zero
		wr(5'h1f, 32'hffffffff);
		rd_chk(5'h1f, 32'h0);
	endtask

	// bases and bank switching
	task automatic t_bank();
		wr(IDX_FB, 32'h1111);
		wr(IDX_SB, 32'hffff);
		wr(IDX_VECTOR_TABLE_BASE, 32'hffffffff);
		#1;
		`CHK(fb, 16'h1111)
		`CHK(vtb, 20'hfffff)
		wr(IDX_FLG, 32'h010);
		rd_chk(IDX_DATA0, 32'h0);
		rd_chk(IDX_ADDR0, 32'h0);
		wr(IDX_FB, 32'h2222);
		#1;
		`CHK(fb, 16'h2222)
		`CHK(sb, 16'hffff)
		rd_chk(IDX_FB, 32'h2222);
		rd_chk(IDX_SB, 32'hffff);
		rd_chk(IDX_VECTOR_TABLE_BASE, 32'hfffff);
		wr(IDX_FLG, 32'h000);
		rd_chk(IDX_DATA0, 32'h5a34);
		`CHK(fb, 16'h1111)
	endtask

	// stack selection and acknowledge side effects
	task automatic t_stack();
		wr(IDX_USP, 32'h3000);
		wr(IDX_ISP, 32'h4000);
		#1;
		`CHK(asp, 16'h4000)
		wr(IDX_FLG, 32'h0c0);
		#1;
		`CHK(asp, 16'h3000)
		wr(IDX_SP, 32'h3100);
		rd_chk(IDX_USP, 32'h3100);
		dp_u.ack(1'b0, 6'h20, 3'h0);
		#1;
		`CHK(flags, 11'h080)
		dp_u.ack(1'b0, 6'h1f, 3'h0);
		#1;
		`CHK(flags, 11'h000)
		wr(IDX_FLG, 32'h0c0);
		dp_u.ack(1'b1, 6'h3f, 3'h5);
		#1;
		`CHK(flags, 11'h500)
		`CHK(asp, 16'h4000)
		wr(IDX_SP, 32'h4100);
		rd_chk(IDX_SP, 32'h4100);
		rd_chk(IDX_USP, 32'h3100);
	endtask

	// arithmetic flags over every operand size
	task automatic t_alu();
		logic [31:0] res [6] = '{32'h100, 32'h80, 32'h8000, 32'h10000, 32'h80000000, 32'h0};
		op_size_e sz [6] = '{SIZE_BYTE, SIZE_BYTE, SIZE_WORD, SIZE_WORD, SIZE_LONG, SIZE_LONG};
		logic [31:0] ext;
		wr(IDX_FLG, 32'h540);
		for (int i = 0; i < 6; i++) begin
			ext = (sz[i] == SIZE_BYTE) ? {{24{res[i][7]}}, res[i][7:0]} :
				(sz[i] == SIZE_WORD) ? {{16{res[i][15]}}, res[i][15:0]} : res[i];
			dp_u.alu(res[i], sz[i], i[0], i[1]);
			#1;
			`CHK(flags[FLG_Z], ext == 32'h0)
			`CHK(flags[FLG_S], ext[31])
			`CHK(flags[FLG_C], i[0])
			`CHK(flags[FLG_O], i[1])
		end
		`CHK(flags[10:4], 7'h54)
	endtask

	// acceptance against priority level and enable
	task automatic t_irq();
		// debug and reserved bits written as zero
		wr(IDX_FLG, 32'h340);
		for (int p = 0; p < 8; p++) begin
			dp_u.req(1'b1, 1'b1, p[2:0]);
			#1;
			`CHK(irq_acc, p > 3)
		end
		wr(IDX_FLG, 32'h300);
		rd_chk(IDX_FLG, 32'h300);
		`CHK(irq_acc, 1'b0)
		dp_u.req(1'b1, 1'b0, 3'h4);
		#1;
		`CHK(irq_acc, 1'b1)
		dp_u.req(1'b1, 1'b0, 3'h3);
		#1;
		`CHK(irq_acc, 1'b0)
		dp_u.req(1'b0, 1'b0, 3'h7);
	endtask

	// program counter wrap and write priority
	task automatic t_pc();
		wr(IDX_PC, 32'hffffe);
		dp_u.step(3'h3);
		#1;
		`CHK(pc, 20'h00001)
		fork
			wr(IDX_PC, 32'h12345);
			dp_u.step(3'h2);
		join
		#1;
		`CHK(pc, 20'h12345)
		rd_chk(IDX_PC, 32'h12345);
	endtask

	// reset in mid-run clears pc, data0, flags, active stack pointer and the read data
	task automatic t_reset();
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		`CHK(pc, 20'h00000)
		`CHK(rdata_o, 32'h0)
		@(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		rd_chk(IDX_DATA0, 32'h0);
		`CHK(flags, 11'h000)
		`CHK(asp, 16'h0000)
	endtask

	// reset, then every scenario in turn
	initial begin
		err_count = 0;
		checked = 0;
		rst_n_i = 1'b0;
		{wr_i, rd_i, addr_i, wdata_i} = 39'h0;
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		t_views();
		t_bank();
		t_stack();
		t_alu();
		t_irq();
		t_pc();
		t_reset();
		give_verdict();
	end

	// hang guard, far beyond the 140 or so cycles the run needs
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire

// ==== hdl/cpu_core_register_file.sv ====
// core register file: banked data and address registers, bases, pc, stacks
`timescale 1ns/10ps
`default_nettype none
module cpu_core_register_file
	import core_regs_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [BUS_AW-1:0] addr_i,
	input wire logic [BUS_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [BUS_DW-1:0] rdata_o,
	// arithmetic unit result
	input wire logic alu_upd_i,
	input wire logic [31:0] alu_result_i,
	input wire op_size_e alu_size_i,
	input wire logic alu_carry_i,
	input wire logic alu_overflow_i,
	// instruction sequencing
	input wire logic pc_advance_i,
	input wire logic [2:0] pc_step_i,
	// interrupts
	input wire logic irq_req_i,
	input wire logic irq_maskable_i,
	input wire logic [2:0] irq_prio_i,
	input wire logic irq_ack_i,
	input wire logic irq_hw_i,
	input wire logic [5:0] sw_int_num_i,
	input wire logic [2:0] ack_level_i,
	output logic irq_accept_o,
	// addressing state for the datapath
	output logic [LONG_ADDR_W-1:0] program_counter_o,
	output logic [WORD_W-1:0] active_stack_pointer_o,
	output logic [WORD_W-1:0] frame_base_o,
	output logic [WORD_W-1:0] static_base_o,
	output logic [LONG_ADDR_W-1:0] vector_table_base_o,
	output logic [FLAG_W-1:0] flags_o
);

	// reset release
	logic rst_meta_reg; // first stage, read only by the second
	logic rst_sync_reg; // synchronised reset, active low

	// release reset through two flops so all state leaves reset together
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// banked storage: two copies of data, address and frame base registers
	logic [WORD_W-1:0] bank_reg [NUM_BANKS][NUM_SLOTS];
	logic [WORD_W-1:0] bank_next [NUM_BANKS][NUM_SLOTS];

	// unbanked registers
	logic [WORD_W-1:0] sb_reg; // static base
	logic [WORD_W-1:0] sb_next;
	logic [LONG_ADDR_W-1:0] vector_table_base_reg; // vector table base
	logic [LONG_ADDR_W-1:0] vector_table_base_next;
	logic [LONG_ADDR_W-1:0] pc_reg; // program counter
	logic [LONG_ADDR_W-1:0] pc_next;
	logic [WORD_W-1:0] usp_reg; // user stack pointer
	logic [WORD_W-1:0] usp_next;
	logic [WORD_W-1:0] isp_reg; // interrupt stack pointer
	logic [WORD_W-1:0] isp_next;
	logic [BUS_DW-1:0] rdata_reg; // read answer, one cycle after strobe
	logic [BUS_DW-1:0] rdata_next;

	// flag state from the flag unit
	logic [FLAG_W-1:0] flags; // current flag word
	logic bank_sel; // current register bank
	logic use_user_sp; // stack flag
	logic flag_wr; // software write of the flag word
	logic [WORD_W-1:0] active_sp; // stack pointer in use

	// RULE_15: bank flag picks the copy
	assign bank_sel = flags[FLG_B];
	// RULE_08: stack flag picks pointer
	assign use_user_sp = flags[FLG_U];
	assign active_sp = use_user_sp ? usp_reg : isp_reg;
	assign flag_wr = wr_i && (addr_i == IDX_FLG);

	// flag register and interrupt gating
	flag_unit u_flag_unit (
		.clk_i(mclk_i),
		.rst_n_i(rst_sync_reg),
		.flag_wr_i(flag_wr),
		.flag_wdata_i(wdata_i[FLAG_W-1:0]),
		.alu_upd_i(alu_upd_i),
		.alu_result_i(alu_result_i),
		.alu_size_i(alu_size_i),
		.alu_carry_i(alu_carry_i),
		.alu_overflow_i(alu_overflow_i),
		.irq_req_i(irq_req_i),
		.irq_maskable_i(irq_maskable_i),
		.irq_prio_i(irq_prio_i),
		.irq_ack_i(irq_ack_i),
		.irq_hw_i(irq_hw_i),
		.sw_int_num_i(sw_int_num_i),
		.ack_level_i(ack_level_i),
		.flags_o(flags),
		.irq_accept_o(irq_accept_o)
	);

	// banked writes land only in the bank that is selected now
	always_comb begin
		bank_next = bank_reg;
		if (wr_i) begin
			case (addr_i)
				// RULE_01: full word access
				IDX_DATA0, IDX_DATA1, IDX_DATA2, IDX_DATA3: begin
					bank_next[bank_sel][addr_i[2:0]] = wdata_i[WORD_W-1:0];
				end
				// RULE_03: address word access
				IDX_ADDR0, IDX_ADDR1: begin
					bank_next[bank_sel][addr_i[2:0]] = wdata_i[WORD_W-1:0];
				end
				// RULE_04: frame base write
				IDX_FB: begin
					bank_next[bank_sel][IDX_FB[2:0]] = wdata_i[WORD_W-1:0];
				end
				// RULE_01: byte halves leave the other half alone
				IDX_D0_LO: begin
					bank_next[bank_sel][IDX_DATA0[2:0]][7:0] = wdata_i[7:0];
				end
				IDX_D0_HI: begin
					bank_next[bank_sel][IDX_DATA0[2:0]][15:8] = wdata_i[7:0];
				end
				IDX_D1_LO: begin
					bank_next[bank_sel][IDX_DATA1[2:0]][7:0] = wdata_i[7:0];
				end
				IDX_D1_HI: begin
					bank_next[bank_sel][IDX_DATA1[2:0]][15:8] = wdata_i[7:0];
				end
				// RULE_02: pairs, low word first register
				IDX_PAIR_EVEN: begin
					bank_next[bank_sel][IDX_DATA0[2:0]] = wdata_i[15:0];
					bank_next[bank_sel][IDX_DATA2[2:0]] = wdata_i[31:16];
				end
				IDX_PAIR_ODD: begin
					bank_next[bank_sel][IDX_DATA1[2:0]] = wdata_i[15:0];
					bank_next[bank_sel][IDX_DATA3[2:0]] = wdata_i[31:16];
				end
				// RULE_03: address pair write
				IDX_ADDR_PAIR: begin
					bank_next[bank_sel][IDX_ADDR0[2:0]] = wdata_i[15:0];
					bank_next[bank_sel][IDX_ADDR1[2:0]] = wdata_i[31:16];
				end
				// other indices do not touch the banks
				default: begin
					bank_next = bank_reg;
				end
			endcase
		end
	end

	// RULE_20: per-bank copies registered
	always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				for (int s = 0; s < NUM_SLOTS; s++) begin
					bank_reg[b][s] <= WORD_RESET;
				end
			end
		end else begin
			bank_reg <= bank_next;
		end
	end

	// unbanked registers: software writes, pc also steps with execution
	always_comb begin
		sb_next = sb_reg;
		vector_table_base_next = vector_table_base_reg;
		usp_next = usp_reg;
		isp_next = isp_reg;
		// RULE_07: pc moves to next instruction
		pc_next = pc_advance_i ? (pc_reg + {17'h0, pc_step_i}) : pc_reg;
		if (wr_i) begin
			case (addr_i)
				// RULE_05: static base write
				IDX_SB: begin
					sb_next = wdata_i[WORD_W-1:0];
				end
				// RULE_06: twenty-bit table base
				IDX_VECTOR_TABLE_BASE: begin
					vector_table_base_next = wdata_i[LONG_ADDR_W-1:0];
				end
				// a jump loads the pc and wins over a step in the same cycle
				IDX_PC: begin
					pc_next = wdata_i[LONG_ADDR_W-1:0];
				end
				IDX_USP: begin
					usp_next = wdata_i[WORD_W-1:0];
				end
				IDX_ISP: begin
					isp_next = wdata_i[WORD_W-1:0];
				end
				// RULE_08: active pointer write goes to the selected one
				IDX_SP: begin
					if (use_user_sp) begin
						usp_next = wdata_i[WORD_W-1:0];
					end else begin
						isp_next = wdata_i[WORD_W-1:0];
					end
				end
				// banked and flag writes are handled elsewhere
				default: begin
					sb_next = sb_reg;
				end
			endcase
		end
	end

	// register the unbanked state
	always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sb_reg <= WORD_RESET;
			vector_table_base_reg <= LONG_RESET;
			pc_reg <= LONG_RESET;
			usp_reg <= WORD_RESET;
			isp_reg <= WORD_RESET;
		end else begin
			sb_reg <= sb_next;
			vector_table_base_reg <= vector_table_base_next;
			pc_reg <= pc_next;
			usp_reg <= usp_next;
			isp_reg <= isp_next;
		end
	end

	// read mux over the current bank; unmapped indices answer zero
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_i) begin
			rdata_next = 32'h00000000;
			case (addr_i)
				IDX_DATA0, IDX_DATA1, IDX_DATA2, IDX_DATA3, IDX_ADDR0, IDX_ADDR1, IDX_FB: begin
					rdata_next[WORD_W-1:0] = bank_reg[bank_sel][addr_i[2:0]];
				end
				IDX_SB: begin
					rdata_next[WORD_W-1:0] = sb_reg;
				end
				IDX_VECTOR_TABLE_BASE: begin
					rdata_next[LONG_ADDR_W-1:0] = vector_table_base_reg;
				end
				IDX_PC: begin
					rdata_next[LONG_ADDR_W-1:0] = pc_reg;
				end
				IDX_USP: begin
					rdata_next[WORD_W-1:0] = usp_reg;
				end
				IDX_ISP: begin
					rdata_next[WORD_W-1:0] = isp_reg;
				end
				IDX_SP: begin
					rdata_next[WORD_W-1:0] = active_sp;
				end
				// RULE_19: whole flag word read back as stored, no bit forced to zero
				IDX_FLG: begin
					rdata_next[FLAG_W-1:0] = flags;
				end
				// RULE_01: byte views in the low byte
				IDX_D0_LO: begin
					rdata_next[7:0] = bank_reg[bank_sel][IDX_DATA0[2:0]][7:0];
				end
				IDX_D0_HI: begin
					rdata_next[7:0] = bank_reg[bank_sel][IDX_DATA0[2:0]][15:8];
				end
				IDX_D1_LO: begin
					rdata_next[7:0] = bank_reg[bank_sel][IDX_DATA1[2:0]][7:0];
				end
				IDX_D1_HI: begin
					rdata_next[7:0] = bank_reg[bank_sel][IDX_DATA1[2:0]][15:8];
				end
				// RULE_02: pair reads
				IDX_PAIR_EVEN: begin
					rdata_next = {bank_reg[bank_sel][IDX_DATA2[2:0]],
						bank_reg[bank_sel][IDX_DATA0[2:0]]};
				end
				IDX_PAIR_ODD: begin
					rdata_next = {bank_reg[bank_sel][IDX_DATA3[2:0]],
						bank_reg[bank_sel][IDX_DATA1[2:0]]};
				end
				// RULE_03: address pair read
				IDX_ADDR_PAIR: begin
					rdata_next = {bank_reg[bank_sel][IDX_ADDR1[2:0]],
						bank_reg[bank_sel][IDX_ADDR0[2:0]]};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	// read data holds its value until the next read strobe
	always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// outputs straight from the registers
	assign rdata_o = rdata_reg;
	assign program_counter_o = pc_reg;
	// RULE_08: datapath sees active pointer
	assign active_stack_pointer_o = active_sp;
	// RULE_04: frame base of current bank
	assign frame_base_o = bank_reg[bank_sel][IDX_FB[2:0]];
	// RULE_05: static base for addressing
	assign static_base_o = sb_reg;
	// RULE_06: table base for vectoring
	assign vector_table_base_o = vector_table_base_reg;
	assign flags_o = flags;

endmodule
`default_nettype wire

// ==== hdl/flag_unit.sv ====
// processor flag register with arithmetic update and interrupt gating
`timescale 1ns/10ps
`default_nettype none
module flag_unit
	import core_regs_pkg::*;
(
	// clock and synchronised reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// software write of the whole flag word
	input wire logic flag_wr_i,
	input wire logic [FLAG_W-1:0] flag_wdata_i,
	// arithmetic unit result
	input wire logic alu_upd_i,
	input wire logic [31:0] alu_result_i,
	input wire op_size_e alu_size_i,
	input wire logic alu_carry_i,
	input wire logic alu_overflow_i,
	// interrupt request and acknowledge
	input wire logic irq_req_i,
	input wire logic irq_maskable_i,
	input wire logic [2:0] irq_prio_i,
	input wire logic irq_ack_i,
	input wire logic irq_hw_i,
	input wire logic [5:0] sw_int_num_i,
	input wire logic [2:0] ack_level_i,
	// state
	output logic [FLAG_W-1:0] flags_o,
	output logic irq_accept_o
);

	logic [FLAG_W-1:0] flags_reg; // current flag word
	logic [FLAG_W-1:0] flags_next; // value for next edge
	logic sign_bit; // msb of result at operand size
	logic zero_res; // result is zero at operand size

	// pick sign and zero at the operand size
	always_comb begin
		case (alu_size_i)
			SIZE_BYTE: begin
				sign_bit = alu_result_i[7];
				zero_res = (alu_result_i[7:0] == 8'h00);
			end
			SIZE_LONG: begin
				sign_bit = alu_result_i[31];
				zero_res = (alu_result_i == 32'h00000000);
			end
			default: begin
				sign_bit = alu_result_i[15];
				zero_res = (alu_result_i[15:0] == 16'h0000);
			end
		endcase
	end

	// next flags: acknowledge beats arithmetic, arithmetic beats software
	always_comb begin
		flags_next = flags_reg;
		if (flag_wr_i) begin
			flags_next = flag_wdata_i;
		end
		if (alu_upd_i) begin
			// RULE_11: carry capture
			flags_next[FLG_C] = alu_carry_i;
			// RULE_12: zero result
			flags_next[FLG_Z] = zero_res;
			// RULE_13: negative result
			flags_next[FLG_S] = sign_bit;
			// RULE_14: overflow capture
			flags_next[FLG_O] = alu_overflow_i;
		end
		if (irq_ack_i) begin
			// RULE_16: acknowledge clears enable
			flags_next[FLG_I] = 1'b0;
			// RULE_09: back to interrupt stack
			if (irq_hw_i || (sw_int_num_i <= SW_INT_ISP_MAX)) begin
				flags_next[FLG_U] = 1'b0;
			end
			// level of a taken hardware interrupt becomes the new processor level
			if (irq_hw_i) begin
				flags_next[FLG_IPL_HI:FLG_IPL_LO] = ack_level_i;
			end
		end
	end

	// register the flag word
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// RULE_10: eleven flag bits out
	assign flags_o = flags_reg;
	// RULE_17: priority above level; RULE_16: enable gates maskable
	assign irq_accept_o = irq_req_i && (irq_prio_i > flags_reg[FLG_IPL_HI:FLG_IPL_LO])
		&& (flags_reg[FLG_I] || !irq_maskable_i);

endmodule
`default_nettype wire

// ==== include/core_regs_pkg.sv ====
// constants, register indices and flag layout of the core register file
// What this block does
// RULE_01: four 16-bit data registers, two byte-splittable
// RULE_02: third and fourth pair with first, second
// RULE_03: two 16-bit address registers, one 32-bit pair
// RULE_04: 16-bit frame base for frame addressing
// RULE_05: 16-bit static base for static addressing
// RULE_06: 20-bit vector table base address
// RULE_07: 20-bit program counter, next instruction
// RULE_08: user and interrupt stack, stack flag selects
// RULE_09: stack flag cleared on interrupt acknowledge; kept for software interrupt numbers above SW_INT_ISP_MAX
// RULE_10: flag register is 11 bits wide
// RULE_11: carry flag captures carry, borrow, shift-out
// RULE_12: zero flag set on zero result
// RULE_13: sign flag set on negative result
// RULE_14: overflow flag set on overflow
// RULE_15: bank flag selects register bank
// RULE_16: interrupt enable gates, cleared on acknowledge
// RULE_17: 3-bit priority level gates interrupt acceptance
// RULE_18: software keeps debug flag at zero
// RULE_19: reserved flag bit written zero, reads undefined
// RULE_20: each bank has own data, address, frame
package core_regs_pkg;

	// widths
	localparam int WORD_W = 16;
	localparam int LONG_ADDR_W = 20;
	localparam int FLAG_W = 11;
	localparam int BUS_AW = 5;
	localparam int BUS_DW = 32;
	localparam int NUM_BANKS = 2;
	localparam int NUM_SLOTS = 7;

	// register indices; banked ones equal their slot number
	localparam logic [4:0] IDX_DATA0 = 5'h00;
	localparam logic [4:0] IDX_DATA1 = 5'h01;
	localparam logic [4:0] IDX_DATA2 = 5'h02;
	localparam logic [4:0] IDX_DATA3 = 5'h03;
	localparam logic [4:0] IDX_ADDR0 = 5'h04;
	localparam logic [4:0] IDX_ADDR1 = 5'h05;
	localparam logic [4:0] IDX_FB = 5'h06;
	localparam logic [4:0] IDX_SB = 5'h07;
	localparam logic [4:0] IDX_VECTOR_TABLE_BASE = 5'h08;
	localparam logic [4:0] IDX_PC = 5'h09;
	localparam logic [4:0] IDX_USP = 5'h0a;
	localparam logic [4:0] IDX_ISP = 5'h0b;
	localparam logic [4:0] IDX_SP = 5'h0c;
	localparam logic [4:0] IDX_FLG = 5'h0d;
	localparam logic [4:0] IDX_D0_LO = 5'h0e;
	localparam logic [4:0] IDX_D0_HI = 5'h0f;
	localparam logic [4:0] IDX_D1_LO = 5'h10;
	localparam logic [4:0] IDX_D1_HI = 5'h11;
	localparam logic [4:0] IDX_PAIR_EVEN = 5'h12;
	localparam logic [4:0] IDX_PAIR_ODD = 5'h13;
	localparam logic [4:0] IDX_ADDR_PAIR = 5'h14;

	// flag bit positions
	localparam int FLG_C = 0;
	localparam int FLG_D = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_S = 3;
	localparam int FLG_B = 4;
	localparam int FLG_O = 5;
	localparam int FLG_I = 6;
	localparam int FLG_U = 7;
	localparam int FLG_IPL_LO = 8;
	localparam int FLG_IPL_HI = 10;

	// reset values
	localparam logic [10:0] FLAGS_RESET = 11'h000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [19:0] LONG_RESET = 20'h00000;

	// software interrupt numbers up to this one switch to the interrupt stack
	localparam logic [5:0] SW_INT_ISP_MAX = 6'h1f;

	// operand size of an arithmetic result
	typedef enum logic [2:0] {
		SIZE_BYTE = 3'b001,
		SIZE_WORD = 3'b010,
		SIZE_LONG = 3'b100
	} op_size_e;

endpackage
